// File: ddr3_mode_ctrl_model.sv
/*
  Behavioural memory controller on the mode register command bus.
  Assumes the bench holds req* until reqDone rises, then drops reqOn.
*/
`timescale 1ns/100ps
module ddr3_mode_ctrl_model (
  input  wire logic        linkClk,
  input  wire logic        reqOn,
  input  wire logic        reqRead,
  input  wire logic [2:0]  reqBank,
  input  wire logic [13:0] reqAddr,
  output logic             reqDone,
  output logic             csLink_b,
  output logic             rasLink_b,
  output logic             casLink_b,
  output logic             weLink_b,
  output logic      [2:0]  bankAddr,
  output logic      [13:0] addrBus
);
  initial begin
    reqDone   = 1'b0;
    csLink_b  = 1'b1;
    rasLink_b = 1'b1;
    casLink_b = 1'b1;
    weLink_b  = 1'b1;
    bankAddr  = 3'h0;
    addrBus   = 14'h0000;
  end

  // one command per request; deselected lines toggle so stale values never pass
  always @(posedge linkClk) begin
    if (reqOn && !reqDone) begin
      csLink_b  <= 1'b0;
      rasLink_b <= reqRead;
      casLink_b <= 1'b0;
      weLink_b  <= reqRead;
      bankAddr  <= reqBank;
      addrBus   <= reqAddr;
      reqDone   <= 1'b1;
    end else begin
      csLink_b  <= 1'b1;
      rasLink_b <= ~rasLink_b;
      casLink_b <= ~casLink_b;
      weLink_b  <= ~weLink_b;
      bankAddr  <= ~bankAddr;
      addrBus   <= ~addrBus;
      reqDone   <= reqOn & reqDone;
    end
  end
endmodule : ddr3_mode_ctrl_model

// File: ddr3_mode_pkg.sv
/*
  Constants for the second and third mode registers of a DDR3 die:
  command decode, field positions, reset values and pattern data.
  Assumes nothing beyond a SystemVerilog package scope.
*/
package ddr3_mode_pkg;

  localparam int unsigned MODE_REG_WIDTH = 18;
  localparam int unsigned ADDR_WIDTH     = 14;
  localparam int unsigned BANK_WIDTH     = 3;

  // bank address that selects each register on a mode register set command
  localparam logic [2:0] MODE_BANK_TWO   = 3'h2;
  localparam logic [2:0] MODE_BANK_THREE = 3'h3;

  // reset values of both registers
  localparam logic [17:0] MODE_TWO_RESET   = 18'h00000;
  localparam logic [17:0] MODE_THREE_RESET = 18'h00000;

  // mode_register_two fields
  localparam int unsigned WR_LAT_LSB       = 3;
  localparam int unsigned WR_LAT_MSB       = 5;
  localparam int unsigned AUTO_RATE_BIT    = 6;
  localparam int unsigned FORCE_DOUBLE_BIT = 7;
  localparam int unsigned DYN_TERM_LSB = 9;
  localparam int unsigned DYN_TERM_MSB = 10;

  // mode_register_three fields
  localparam int unsigned PAT_EN_BIT  = 2;
  localparam int unsigned PAT_SEL_LSB = 0;
  localparam int unsigned PAT_SEL_MSB = 1;
  localparam logic [1:0]  PAT_SEL_PREDEFINED = 2'h0;

  // write_cas_latency code to cycles: code 0 gives 5 cycles, code 6 the last defined
  localparam logic [3:0] WR_LAT_BASE_CYCLES = 4'h5;
  localparam logic [2:0] WR_LAT_CODE_MAX    = 3'h6;

  // calibration pattern: burst of eight beats, first beat 0, alternating
  localparam logic [3:0] PAT_BEATS      = 4'h8;
  localparam logic [7:0] PAT_BURST_DATA = 8'hAA;

  // command pins {ras_b, cas_b, we_b} with chip select low
  typedef enum logic [2:0] {
    CMD_MODE_SET = 3'h0,
    CMD_READ     = 3'h5,
    CMD_WRITE    = 3'h4
  } cmd_code_e;

  // decoded write_cas_latency in cycles, 0 for an undefined code
  function automatic logic [3:0] wrLatCycles(input logic [2:0] code);
    if (code > WR_LAT_CODE_MAX) begin
      return 4'h0;
    end
    return WR_LAT_BASE_CYCLES + {1'b0, code};
  endfunction : wrLatCycles

endpackage : ddr3_mode_pkg

// File: ddr3_mode_regs_two_three.sv
/*
  Second and third mode registers of a DDR3 die. The command bus is decoded
  on linkClk; settings cross to clk by toggle handshake and drive write
  latency, self-refresh rate and termination select. Pattern read bursts are
  produced on linkClk.
  Assumes: command pins are synchronous to linkClk; tempAboveNormal is a pin;
  writeBurstActive, writeLevelingActive, nominalTermSel and additiveLatency
  come from logic on clk.
*/
// Contract
// - register keeps value until rewritten
// - bits 5:3 give write latency
// - bit 6 enables automatic rate, else single
// - automatic mode doubles rate when hot
// - bit 7 forces double rate always
// - bits 10:9 select write termination
// - write termination during bursts only
// - works without nominal; otherwise high impedance
// - no write termination during write leveling
// - bit 2 selects pattern reads
// - select 00 returns predefined pattern
// - select bits ignored in normal mode
// - every read redirected, repeatable
// - reset works during pattern mode
// - pattern alternates zero one, zero first
// - bank 010 and 011 select registers
`timescale 1ns/100ps
module ddr3_mode_regs_two_three
  import ddr3_mode_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        linkClk,
  input  wire logic        csLink_b,
  input  wire logic        rasLink_b,
  input  wire logic        casLink_b,
  input  wire logic        weLink_b,
  input  wire logic [2:0]  bankAddr,
  input  wire logic [13:0] addrBus,
  input  wire logic        tempAboveNormal,
  input  wire logic        writeBurstActive,
  input  wire logic        writeLevelingActive,
  input  wire logic [2:0]  nominalTermSel,
  input  wire logic [3:0]  additiveLatency,
  output logic      [3:0]  writeCasLatency,
  output logic      [4:0]  totalWriteLatency,
  output logic             wrLatCodeUndefined,
  output logic             selfRefreshDouble,
  output logic             dynTermEnabled,
  output logic             termIsWrite,
  output logic      [1:0]  writeTermCode,
  output logic             termHighZ,
  output logic             readFromPattern,
  output logic             patternValid,
  output logic             patternDq
);

  typedef enum logic {
    PAT_IDLE,
    PAT_BURST
  } pat_state_e;

  // link domain
  logic        linkRst_b;
  logic        cmdMode;
  logic        cmdRead;
  logic        writeTwo;
  logic        writeThree;
  logic [17:0] modeTwoLink_q;
  logic [17:0] modeThreeLink_q;
  logic        modeTwoToggle_q;
  logic        modeThreeToggle_q;
  logic        patStart;
  pat_state_e  patState_q;
  pat_state_e  patState_d;
  logic [3:0]  beatCnt_q;
  logic [3:0]  beatCnt_d;

  // clk domain
  logic [1:0]  toggleSync;
  logic [1:0]  toggleSeen_q;
  logic        tempHot;
  logic [17:0] modeTwo_q;
  logic [17:0] modeThree_q;
  logic [2:0]  wrLatCode;
  logic [1:0]  dynField;
  logic        writeTermNow;

  sync_two_flop #(
    .WIDTH (1)
  ) u_link_reset (
    .clk    (linkClk),
    .async  (rst_b),
    .synced (linkRst_b)
  );

  // command decode
  assign cmdMode  = !csLink_b && ({rasLink_b, casLink_b, weLink_b} == CMD_MODE_SET);
  // read and read_with_auto_precharge share the code, only A10 differs
  assign cmdRead  = !csLink_b && ({rasLink_b, casLink_b, weLink_b} == CMD_READ);
  assign writeTwo   = cmdMode && (bankAddr == MODE_BANK_TWO);
  assign writeThree = cmdMode && (bankAddr == MODE_BANK_THREE);

  // only a matching command or reset touches each register; nothing else alters it
  always_ff @(posedge linkClk) begin
    if (!linkRst_b) begin
      modeTwoLink_q   <= MODE_TWO_RESET;
      modeTwoToggle_q <= 1'b0;
    end else if (writeTwo) begin
      modeTwoLink_q   <= {4'h0, addrBus};
      modeTwoToggle_q <= !modeTwoToggle_q;
    end
  end

  // reset clears pattern mode too, so a stuck calibration can be recovered
  always_ff @(posedge linkClk) begin
    if (!linkRst_b) begin
      modeThreeLink_q   <= MODE_THREE_RESET;
      modeThreeToggle_q <= 1'b0;
    end else if (writeThree) begin
      modeThreeLink_q   <= {4'h0, addrBus};
      modeThreeToggle_q <= !modeThreeToggle_q;
    end
  end

  // pattern read engine; an unreserved select is required to start a burst
  assign patStart = cmdRead && modeThreeLink_q[PAT_EN_BIT] &&
                    (modeThreeLink_q[PAT_SEL_MSB:PAT_SEL_LSB] == PAT_SEL_PREDEFINED);

  always_comb begin
    patState_d = patState_q;
    beatCnt_d  = beatCnt_q;
    unique case (patState_q)
      PAT_IDLE: begin
        if (patStart) begin
          patState_d = PAT_BURST;
          beatCnt_d  = 4'h0;
        end
      end
      PAT_BURST: begin
        if (patStart) begin
          beatCnt_d = 4'h0;
        end else if (beatCnt_q == PAT_BEATS - 4'h1) begin
          patState_d = PAT_IDLE;
        end else begin
          beatCnt_d = beatCnt_q + 4'h1;
        end
      end
    endcase
    if (!modeThreeLink_q[PAT_EN_BIT]) begin
      patState_d = PAT_IDLE;
    end
  end

  always_ff @(posedge linkClk) begin
    if (!linkRst_b) begin
      patState_q <= PAT_IDLE;
      beatCnt_q  <= 4'h0;
    end else begin
      patState_q <= patState_d;
      beatCnt_q  <= beatCnt_d;
    end
  end

  always_ff @(posedge linkClk) begin
    if (!linkRst_b) begin
      patternValid <= 1'b0;
      patternDq    <= 1'b0;
    end else begin
      patternValid <= (patState_d == PAT_BURST);
      patternDq    <= (patState_d == PAT_BURST) && PAT_BURST_DATA[beatCnt_d[2:0]];
    end
  end

  always_ff @(posedge linkClk) begin
    if (!linkRst_b) begin
      readFromPattern <= 1'b0;
    end else begin
      readFromPattern <= modeThreeLink_q[PAT_EN_BIT];
    end
  end

  // crossing into clk: the word is quasi-static once the toggle has moved,
  // since the controller waits the mode update delay before relying on it
  sync_two_flop #(
    .WIDTH (2)
  ) u_toggle_sync (
    .clk    (clk),
    .async  ({modeThreeToggle_q, modeTwoToggle_q}),
    .synced (toggleSync)
  );

  sync_two_flop #(
    .WIDTH (1)
  ) u_temp_sync (
    .clk    (clk),
    .async  (tempAboveNormal),
    .synced (tempHot)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      toggleSeen_q <= 2'h0;
    end else begin
      toggleSeen_q <= toggleSync;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      modeTwo_q <= MODE_TWO_RESET;
    end else if (toggleSync[0] != toggleSeen_q[0]) begin
      modeTwo_q <= modeTwoLink_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      modeThree_q <= MODE_THREE_RESET;
    end else if (toggleSync[1] != toggleSeen_q[1]) begin
      modeThree_q <= modeThreeLink_q;
    end
  end

  assign wrLatCode = modeTwo_q[WR_LAT_MSB:WR_LAT_LSB];
  assign dynField  = modeTwo_q[DYN_TERM_MSB:DYN_TERM_LSB];

  // write latency; an undefined code reads as zero cycles and is flagged
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      writeCasLatency    <= 4'h0;
      totalWriteLatency  <= 5'h00;
      wrLatCodeUndefined <= 1'b0;
    end else begin
      writeCasLatency    <= wrLatCycles(wrLatCode);
      totalWriteLatency  <= {1'b0, wrLatCycles(wrLatCode)} + {1'b0, additiveLatency};
      wrLatCodeUndefined <= (wrLatCycles(wrLatCode) == 4'h0);
    end
  end

  // both bits set is illegal; the forced setting then simply wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      selfRefreshDouble <= 1'b0;
    end else begin
      selfRefreshDouble <= modeTwo_q[FORCE_DOUBLE_BIT] ||
                           (modeTwo_q[AUTO_RATE_BIT] && tempHot);
    end
  end

  assign writeTermNow = writeBurstActive && (dynField != 2'h0) &&
                        !writeLevelingActive;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dynTermEnabled <= 1'b0;
      writeTermCode  <= 2'h0;
      termIsWrite    <= 1'b0;
      termHighZ      <= 1'b1;
    end else begin
      dynTermEnabled <= (dynField != 2'h0);
      writeTermCode  <= dynField;
      termIsWrite    <= writeTermNow;
      termHighZ      <= !writeTermNow && (nominalTermSel == 3'h0);
    end
  end

  // link-domain checks
  a_mode_two_store: assert property (@(posedge linkClk) disable iff (!linkRst_b)
    writeTwo |=> modeTwoLink_q == {4'h0, $past(addrBus)})
    else $error("register two not loaded by its command");

  a_mode_two_hold: assert property (@(posedge linkClk) disable iff (!linkRst_b)
    !writeTwo |=> $stable(modeTwoLink_q))
    else $error("register two changed without its command");

  a_mode_three_hold: assert property (@(posedge linkClk) disable iff (!linkRst_b)
    (cmdMode && bankAddr != MODE_BANK_THREE) |=> $stable(modeThreeLink_q))
    else $error("register three changed by another bank");

  // first and eighth beat both valid; a mode set inside a burst is illegal
  a_pattern_burst_len: assert property (@(posedge linkClk) disable iff (!linkRst_b)
    (patStart && !writeThree) ##1 modeThreeLink_q[PAT_EN_BIT][*8]
      |-> patternValid && $past(patternValid, 7))
    else $error("pattern burst shorter than eight beats");

  a_pattern_alternate: assert property (@(posedge linkClk) disable iff (!linkRst_b)
    (patStart && !writeThree) ##1 !patStart |-> !patternDq ##1 patternDq)
    else $error("pattern does not start zero then one");

  a_pattern_ignored: assert property (@(posedge linkClk) disable iff (!linkRst_b)
    !modeThreeLink_q[PAT_EN_BIT] |=> !patternValid)
    else $error("pattern data while in normal mode");

  // clk-domain checks
  a_write_latency_sum: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> totalWriteLatency == {1'b0, writeCasLatency} + {1'b0, $past(additiveLatency)})
    else $error("total write latency not the sum");

  a_mode_three_cross: assert property (@(posedge clk) disable iff (!rst_b)
    (toggleSync[1] != toggleSeen_q[1]) |=> modeThree_q == $past(modeThreeLink_q))
    else $error("register three not carried across the crossing");

  a_forced_double: assert property (@(posedge clk) disable iff (!rst_b)
    modeTwo_q[FORCE_DOUBLE_BIT] |=> selfRefreshDouble)
    else $error("forced double rate not applied");

  a_refresh_single: assert property (@(posedge clk) disable iff (!rst_b)
    (!modeTwo_q[AUTO_RATE_BIT] && !modeTwo_q[FORCE_DOUBLE_BIT]) |=> !selfRefreshDouble)
    else $error("double rate without any enable");

  a_auto_rate_hot: assert property (@(posedge clk) disable iff (!rst_b)
    (modeTwo_q[AUTO_RATE_BIT] && tempHot) |=> selfRefreshDouble)
    else $error("automatic rate did not double when hot");

  a_dyn_term_write: assert property (@(posedge clk) disable iff (!rst_b)
    (writeBurstActive && dynField != 2'h0 && !writeLevelingActive)
      |=> termIsWrite && !termHighZ && writeTermCode == $past(dynField))
    else $error("write termination not applied in burst");

  a_dyn_term_leveling: assert property (@(posedge clk) disable iff (!rst_b)
    (writeLevelingActive || !writeBurstActive) |=> !termIsWrite)
    else $error("write termination outside a burst or during leveling");

  a_term_high_z: assert property (@(posedge clk) disable iff (!rst_b)
    (!writeBurstActive && nominalTermSel == 3'h0) |=> termHighZ)
    else $error("idle termination not high impedance");

  c_pattern_burst: cover property (@(posedge linkClk) disable iff (!linkRst_b)
    patStart ##1 patternValid[*8]);

  c_auto_rate: cover property (@(posedge clk) disable iff (!rst_b)
    modeTwo_q[AUTO_RATE_BIT] && tempHot ##1 selfRefreshDouble);

  c_dyn_term: cover property (@(posedge clk) disable iff (!rst_b)
    termIsWrite ##1 !termIsWrite);

  c_mode_three: cover property (@(posedge linkClk) disable iff (!linkRst_b)
    writeThree ##1 modeThreeLink_q[PAT_EN_BIT]);

endmodule : ddr3_mode_regs_two_three

// File: ddr3_mode_regs_two_three_tb.sv
/*
  Self-checking bench: mode sets and reads through the controller model.
  Assumes mode settings reach the clk outputs within twenty clk cycles.
*/
`timescale 1ns/100ps
module ddr3_mode_regs_two_three_tb import ddr3_mode_pkg::*; ;
  logic        clk, linkClk, rst_b, tempAboveNormal, writeBurstActive;
  logic        writeLevelingActive, reqOn, reqRead, reqDone;
  logic        csLink_b, rasLink_b, casLink_b, weLink_b;
  logic [2:0]  nominalTermSel, reqBank, bankAddr;
  logic [3:0]  additiveLatency, writeCasLatency;
  logic [13:0] reqAddr, addrBus;
  logic [4:0]  totalWriteLatency;
  logic [1:0]  writeTermCode;
  logic        wrLatCodeUndefined, selfRefreshDouble, dynTermEnabled, termIsWrite;
  logic        termHighZ, readFromPattern, patternValid, patternDq;
  int          n_fail, num_checks;
  logic        beats[$];
  logic [3:0]  rt[4] = '{4'h2, 4'h8, 4'hB, 4'h5};

  ddr3_mode_regs_two_three dut (.clk, .rst_b, .linkClk, .csLink_b, .rasLink_b,
    .casLink_b, .weLink_b, .bankAddr, .addrBus, .tempAboveNormal, .writeBurstActive,
    .writeLevelingActive, .nominalTermSel, .additiveLatency, .writeCasLatency,
    .totalWriteLatency, .wrLatCodeUndefined, .selfRefreshDouble, .dynTermEnabled,
    .termIsWrite, .writeTermCode, .termHighZ, .readFromPattern, .patternValid,
    .patternDq);
  ddr3_mode_ctrl_model ctrl (.linkClk, .reqOn, .reqRead, .reqBank, .reqAddr,
    .reqDone, .csLink_b, .rasLink_b, .casLink_b, .weLink_b, .bankAddr, .addrBus);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #3.1;
    forever #24 linkClk = ~linkClk;
  end
  // beats sampled mid-cycle, away from the launching edge
  always @(negedge linkClk) begin
    if (patternValid === 1'b1) begin
      beats.push_back(patternDq);
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmd(input logic rd, input logic [2:0] bank, input logic [13:0] addr);
    int n;
    @(negedge clk);
    reqRead = rd;
    reqBank = bank;
    reqAddr = addr;
    reqOn   = 1'b1;
    for (n = 0; n < 100 && reqDone !== 1'b1; n++) @(negedge clk);
    check("command accepted", reqDone, 1'b1);
    reqOn = 1'b0;
    for (n = 0; n < 100 && reqDone !== 1'b0; n++) @(negedge clk);
    // spacing covers the crossing before outputs are relied on
    repeat (20) @(negedge clk);
  endtask : cmd

  task automatic readBurst(input logic [13:0] addr, input int n);
    beats.delete();
    cmd(1'b1, 3'h0, addr);
    repeat (40) @(negedge clk);
    check("beat count", beats.size(), n);
    foreach (beats[k]) check("patternDq", beats[k], k % 2);
  endtask : readBurst

  task automatic term(input logic b, l, input logic [2:0] nom, input logic w, z);
    writeBurstActive    = b;
    writeLevelingActive = l;
    nominalTermSel      = nom;
    repeat (3) @(negedge clk);
    check("termIsWrite", termIsWrite, w);
    check("termHighZ", termHighZ, z);
  endtask : term

  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    int c;
    int exp;
    rst_b = 1'b0;
    tempAboveNormal = 1'b0;
    writeBurstActive = 1'b0;
    writeLevelingActive = 1'b0;
    nominalTermSel = 3'h0;
    additiveLatency = 4'h3;
    reqOn = 1'b0;
    reqRead = 1'b0;
    reqBank = 3'h0;
    reqAddr = 14'h0000;
    // held past twenty cycles: the link side needs four of its own edges
    repeat (24) @(negedge clk);
    check("termHighZ rst", termHighZ, 1'b1);
    check("readFromPattern rst", readFromPattern, 1'b0);
    rst_b = 1'b1;
    repeat (20) @(negedge clk);
    for (c = 0; c < 8; c++) begin
      additiveLatency = 4'(c);
      cmd(1'b0, MODE_BANK_TWO, 14'(c << 3));
      exp = (c == 7) ? 0 : c + 5;
      check("writeCasLatency", writeCasLatency, exp);
      check("totalWriteLatency", totalWriteLatency, exp + c);
      check("wrLatCodeUndefined", wrLatCodeUndefined, c == 7);
    end
    cmd(1'b0, MODE_BANK_TWO, 14'h0010);
    cmd(1'b0, 3'h0, 14'h0028);
    cmd(1'b0, 3'h1, 14'h0028);
    cmd(1'b0, MODE_BANK_THREE, 14'h0000);
    check("writeCasLatency kept", writeCasLatency, 4'h7);
    for (c = 0; c < 4; c++) begin
      tempAboveNormal = rt[c][1];
      cmd(1'b0, MODE_BANK_TWO, {6'h00, rt[c][2], rt[c][3], 6'h00});
      check("selfRefreshDouble", selfRefreshDouble, rt[c][0]);
    end
    cmd(1'b0, MODE_BANK_TWO, 14'h0400);
    check("dynTermEnabled", dynTermEnabled, 1'b1);
    check("writeTermCode", writeTermCode, 2'h2);
    term(1'b0, 1'b0, 3'h0, 1'b0, 1'b1);
    term(1'b1, 1'b0, 3'h0, 1'b1, 1'b0);
    term(1'b1, 1'b1, 3'h1, 1'b0, 1'b0);
    term(1'b0, 1'b0, 3'h1, 1'b0, 1'b0);
    cmd(1'b0, MODE_BANK_TWO, 14'h0000);
    check("dynTermEnabled off", dynTermEnabled, 1'b0);
    term(1'b1, 1'b0, 3'h1, 1'b0, 1'b0);
    cmd(1'b0, MODE_BANK_THREE, 14'h0001);
    check("readFromPattern", readFromPattern, 1'b0);
    readBurst(14'h0000, 0);
    cmd(1'b0, MODE_BANK_THREE, 14'h0004);
    check("readFromPattern", readFromPattern, 1'b1);
    readBurst(14'h0000, 8);
    readBurst(14'h0400, 8);
    cmd(1'b0, MODE_BANK_THREE, 14'h0005);
    readBurst(14'h0000, 0);
    cmd(1'b0, MODE_BANK_THREE, 14'h0004);
    rst_b = 1'b0;
    repeat (24) @(negedge clk);
    check("readFromPattern reset", readFromPattern, 1'b0);
    rst_b = 1'b1;
    repeat (20) @(negedge clk);
    readBurst(14'h0000, 0);
    report_and_stop();
  end
endmodule : ddr3_mode_regs_two_three_tb

// File: sync_two_flop.sv
/*
  Two flip-flop level synchroniser, one bit per lane.
  Assumes inputs are levels that stay put for at least two destination edges.
*/
`timescale 1ns/100ps
module sync_two_flop #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_q;

  // no reset: also carries the reset itself into a foreign domain
  always_ff @(posedge clk) begin
    meta_q <= async;
    synced <= meta_q;
  end

endmodule : sync_two_flop
